// File: card_cmd_pkg.sv
// Constants and types for the card command front end
package card_cmd_pkg;
    localparam int CMD_BITS = 48;
    localparam int CRC_BITS = 7;
    localparam logic [6:0] CRC_POLY = 7'h09;
    localparam logic [5:0] OP_RESET = 6'h00;
    localparam logic [5:0] OP_INIT = 6'h01;
    localparam logic [5:0] OP_STOP = 6'h0c;
    localparam logic [5:0] OP_APP_INIT = 6'h29;
    localparam logic [5:0] OP_APP_PREFIX = 6'h37;
    localparam logic [5:0] OP_READ_OCR = 6'h3a;
    localparam logic [5:0] OP_CRC_ONOFF = 6'h3b;
    localparam logic [5:0] OP_READ_ONE = 6'h11;
    localparam logic [5:0] OP_READ_MANY = 6'h12;
    localparam logic [5:0] OP_WRITE_ONE = 6'h18;
    localparam logic [5:0] OP_WRITE_MANY = 6'h19;
    localparam logic [5:0] OP_ERASE_START = 6'h20;
    localparam logic [5:0] OP_ERASE_END = 6'h21;
    localparam logic [5:0] OP_ERASE = 6'h26;
    localparam logic [5:0] OP_LOCK = 6'h2a;
    // Response bit positions
    localparam int RB_IDLE = 0;
    localparam int RB_ERASE_SEQ = 4;
    localparam int RB_ILLEGAL = 2;
    localparam int RB_CRC = 3;
    localparam int RB_PARAM = 6;
    localparam int RB_ERASE_RST = 1;
    // Timing: clk_in at 250 MHz
    localparam int CLK_MHZ = 250;
    localparam int READ_TMO_MS = 100;
    localparam int WRITE_TMO_MS = 250;
    localparam int READ_TMO_CYC = READ_TMO_MS * 1000 * CLK_MHZ;
    localparam int WRITE_TMO_CYC = WRITE_TMO_MS * 1000 * CLK_MHZ;
    localparam int TMO_FACTOR = 100;
    localparam int INIT_CYC = 16;
    localparam logic [31:0] OCR_RESET = 32'h00ff8000;
    typedef enum logic [1:0] {ST_IDLE, ST_READY, ST_READ, ST_BUSY} card_state_t;
endpackage

// File: card_link_if.sv
// Carrier between the link-clock framer and the core
`timescale 1ns/10ps
`default_nettype none
interface card_link_if;
    logic cmd_toggle;
    logic [47:0] cmd_frame;
    logic rsp_toggle;
    logic [7:0] rsp_byte;
    logic busy_level;
    modport framer (output cmd_toggle, output cmd_frame,
        input rsp_toggle, input rsp_byte, input busy_level);
    modport core (input cmd_toggle, input cmd_frame,
        output rsp_toggle, output rsp_byte, output busy_level);
endinterface
`default_nettype wire

// File: card_spi_framer.sv
// Link-clock side: shifts command frames in and responses out
`timescale 1ns/10ps
`default_nettype none
module card_spi_framer
    import card_cmd_pkg::*;
(
    input wire logic sclk_in,
    input wire logic sys_rst_in,
    input wire logic cs_n_in,
    input wire logic mosi_in,
    output logic miso_out,
    output logic miso_oe_out,
    card_link_if.framer link
);
    logic [47:0] shift;
    logic [5:0] nbits;
    logic cmd_tg;
    logic [47:0] frame;
    logic [1:0] rsp_sync;
    logic rsp_seen;
    logic [7:0] out_sr;
    logic [3:0] out_left;
    logic [1:0] busy_sync;
    logic [2:0] bitpos;

    assign link.cmd_toggle = cmd_tg;
    assign link.cmd_frame = frame;

    // Frame starts on a 0 then 1; MSB first
    always_ff @(posedge sclk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            shift <= '0;
            nbits <= '0;
            cmd_tg <= 1'b0;
            frame <= '0;
        end else if (cs_n_in) begin
            nbits <= '0;
        end else if (nbits == 6'd0 && mosi_in) begin
            nbits <= '0;
        end else if (nbits == 6'(CMD_BITS - 1)) begin
            frame <= {shift[46:0], mosi_in};
            cmd_tg <= ~cmd_tg;
            nbits <= '0;
        end else begin
            shift <= {shift[46:0], mosi_in};
            nbits <= nbits + 6'd1;
        end
    end

    always_ff @(posedge sclk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            rsp_sync <= '0;
            busy_sync <= '0;
        end else begin
            rsp_sync <= {rsp_sync[0], link.rsp_toggle};
            busy_sync <= {busy_sync[0], link.busy_level};
        end
    end

    // Bit position within the byte, counted from chip-select fall
    always_ff @(posedge sclk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            bitpos <= '0;
        end else if (cs_n_in) begin
            bitpos <= '0;
        end else begin
            bitpos <= bitpos + 3'd1;
        end
    end

    // Busy drops only on a link edge; deselect releases the line at the next falling link edge
    always_ff @(negedge sclk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            rsp_seen <= 1'b0;
            out_sr <= 8'hff;
            out_left <= '0;
            miso_out <= 1'b1;
            miso_oe_out <= 1'b0;
        end else begin
            miso_oe_out <= ~cs_n_in;
            // Response waits for a byte boundary; the host reads whole bytes
            if (rsp_sync[1] != rsp_seen && bitpos == 3'd0) begin
                rsp_seen <= rsp_sync[1];
                out_sr <= {link.rsp_byte[6:0], 1'b1};
                out_left <= 4'd7;
                miso_out <= link.rsp_byte[7];
            end else if (out_left != 4'd0) begin
                out_sr <= {out_sr[6:0], 1'b1};
                out_left <= out_left - 4'd1;
                miso_out <= out_sr[7];
            end else begin
                miso_out <= ~busy_sync[1];
            end
        end
    end
endmodule // card_spi_framer
`default_nettype wire

// File: card_spi_cmd.sv
// Card command acceptance, init sequence and operation timeouts
`timescale 1ns/10ps
`default_nettype none
module card_spi_cmd
    import card_cmd_pkg::*;
#(
    parameter int READ_TMO = READ_TMO_CYC,
    parameter int WRITE_TMO = WRITE_TMO_CYC,
    parameter int TIME_W = 32
) (
    input wire logic clk_in,
    input wire logic sys_rst_in,
    input wire logic clk_en_in,
    input wire logic sclk_in,
    input wire logic cs_n_in,
    input wire logic mosi_in,
    output logic card_serial_output_out,
    output logic card_serial_output_oe_out,
    input wire logic locked_in,
    input wire logic [TIME_W-1:0] async_access_time_in,
    input wire logic [TIME_W-1:0] clocked_access_cycles_in,
    input wire logic [2:0] write_speed_factor_in,
    input wire logic [15:0] write_block_unit_in,
    input wire logic op_done_in,
    input wire logic op_error_in,
    output logic [31:0] operating_conditions_reg_out,
    output logic [1:0] state_out,
    output logic crc_check_out,
    output logic timeout_out,
    output logic [TIME_W-1:0] op_limit_out
);
    if (TIME_W < 8 || READ_TMO < 1 || WRITE_TMO < 1) begin : g_bad_params
        $error("card_spi_cmd: bad parameters");
    end

    card_link_if link();
    card_state_t state;
    logic [2:0] cmd_sync;
    logic cmd_seen;
    logic rsp_tg;
    logic [7:0] rsp;
    logic crc_on;
    logic app_next;
    logic [1:0] erase_step;
    logic [TIME_W-1:0] tmo_cnt;
    logic [TIME_W-1:0] tmo_lim;
    logic tmo_flag;
    logic [7:0] init_cnt;
    logic busy_src;
    logic [31:0] operating_conditions_reg;

    card_spi_framer u_framer (
        .sclk_in(sclk_in),
        .sys_rst_in(sys_rst_in),
        .cs_n_in(cs_n_in),
        .mosi_in(mosi_in),
        .miso_out(card_serial_output_out),
        .miso_oe_out(card_serial_output_oe_out),
        .link(link.framer)
    );

    function automatic logic [6:0] crc7(input logic [39:0] bits);
        logic [6:0] c;
        logic fb;
        c = '0;
        for (int i = 39; i >= 0; i--) begin
            fb = bits[i] ^ c[6];
            c = {c[5:0], 1'b0} ^ (fb ? CRC_POLY : 7'h00);
        end
        return c;
    endfunction

    function automatic logic class_ok(input logic [5:0] op);
        // Class 0 holds only the basic commands, not every low index
        return op == OP_RESET || op == OP_INIT || op == 6'h09
            || op == 6'h0a || op == OP_STOP || op == 6'h0d
            || op == OP_READ_OCR || op == OP_CRC_ONOFF || op == OP_LOCK;
    endfunction

    function automatic logic known(input logic [5:0] op);
        return class_ok(op) || op == OP_READ_ONE || op == OP_READ_MANY
            || op == 6'h10 || op == OP_WRITE_ONE || op == OP_WRITE_MANY
            || op == 6'h1b || (op >= 6'h1c && op <= 6'h1e)
            || op == OP_ERASE_START || op == OP_ERASE_END
            || op == OP_ERASE || op == OP_APP_PREFIX || op == 6'h38
            || op == OP_APP_INIT;
    endfunction

    // Event from link domain: toggle through three flops
    always_ff @(posedge clk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            cmd_sync <= '0;
        end else if (clk_en_in) begin
            cmd_sync <= {cmd_sync[1:0], link.cmd_toggle};
        end
    end

    wire new_cmd = cmd_sync[2] != cmd_seen;
    wire [47:0] fr = link.cmd_frame;
    wire [5:0] op = fr[45:40];
    wire [31:0] arg = fr[39:8];
    wire crc_bad = crc_on && (crc7(fr[47:8]) != fr[7:1]);
    wire in_idle = state == ST_IDLE;
    wire rd_reject = state == ST_READ && op != OP_STOP;
    wire idle_reject = in_idle && !(op == OP_INIT || op == OP_APP_INIT
        || op == OP_CRC_ONOFF || op == OP_READ_OCR
        || op == OP_APP_PREFIX || op == OP_RESET);
    wire lock_reject = locked_in && !class_ok(op);
    wire erase_bad = (op == OP_ERASE_END && erase_step != 2'd1)
        || (op == OP_ERASE && erase_step != 2'd2);
    wire op_bad = op == OP_INIT && arg != 32'h0;
    wire illegal = !known(op) || (op == OP_APP_INIT && !app_next);

    // Frame is stable: toggle lags the frame by three fast clocks
    always_ff @(posedge clk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            cmd_seen <= 1'b0;
            rsp_tg <= 1'b0;
            rsp <= 8'hff;
        end else if (clk_en_in && new_cmd) begin
            cmd_seen <= cmd_sync[2];
            rsp_tg <= ~rsp_tg;
            rsp <= '0;
            rsp[RB_IDLE] <= in_idle && op != OP_INIT && op != OP_APP_INIT
                || (in_idle && init_cnt != 8'd0) || op == OP_RESET;
            rsp[RB_CRC] <= crc_bad;
            rsp[RB_ILLEGAL] <= illegal || rd_reject || idle_reject
                || lock_reject || state == ST_BUSY;
            rsp[RB_PARAM] <= op_bad;
            rsp[RB_ERASE_SEQ] <= erase_bad;
        end
    end

    wire accept = new_cmd && !crc_bad && !illegal && !rd_reject
        && !idle_reject && !lock_reject && state != ST_BUSY
        && !erase_bad && !op_bad;

    // Card state, init countdown and CRC mode
    always_ff @(posedge clk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            state <= ST_IDLE;
            init_cnt <= 8'(INIT_CYC);
            crc_on <= 1'b0;
            app_next <= 1'b0;
            erase_step <= '0;
            operating_conditions_reg <= OCR_RESET;
        end else if (clk_en_in) begin
            if (state == ST_IDLE && init_cnt != 8'd0) begin
                init_cnt <= init_cnt - 8'd1;
            end
            if (accept) begin
                app_next <= op == OP_APP_PREFIX;
                if (op == OP_CRC_ONOFF) begin
                    crc_on <= arg[0];
                end
                if (op == OP_ERASE_START) begin
                    erase_step <= 2'd1;
                end else if (op == OP_ERASE_END) begin
                    erase_step <= 2'd2;
                end else if (op != OP_READ_OCR) begin
                    erase_step <= 2'd0;
                end
            end
            if (accept && op == OP_RESET) begin
                state <= ST_IDLE;
                init_cnt <= 8'(INIT_CYC);
            end else begin
                unique case (state)
                    ST_IDLE: begin
                        if (accept && init_cnt == 8'd0
                            && (op == OP_INIT || op == OP_APP_INIT)) begin
                            state <= ST_READY;
                        end
                    end
                    ST_READY: begin
                        if (accept && (op == OP_READ_ONE
                            || op == OP_READ_MANY)) begin
                            state <= ST_READ;
                        end else if (accept && (op == OP_WRITE_ONE
                            || op == OP_WRITE_MANY || op == OP_ERASE)) begin
                            state <= ST_BUSY;
                        end
                    end
                    ST_READ: begin
                        if ((accept && op == OP_STOP) || op_done_in
                            || op_error_in || tmo_flag) begin
                            state <= ST_READY;
                        end
                    end
                    ST_BUSY: begin
                        if (op_done_in || op_error_in || tmo_flag) begin
                            state <= ST_READY;
                        end
                    end
                endcase
            end
        end
    end

    // Limit: 100x typical time, capped by the fixed ceiling
    wire [TIME_W-1:0] access = async_access_time_in
        + clocked_access_cycles_in;
    wire [TIME_W-1:0] prog = TIME_W'(access << write_speed_factor_in);
    wire [TIME_W-1:0] erase_t = TIME_W'(prog * write_block_unit_in);

    always_ff @(posedge clk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            tmo_cnt <= '0;
            tmo_lim <= '0;
            tmo_flag <= 1'b0;
        end else if (clk_en_in) begin
            tmo_flag <= 1'b0;
            if (accept) begin
                tmo_cnt <= '0;
                if (op == OP_READ_ONE || op == OP_READ_MANY) begin
                    tmo_lim <= (TIME_W'(TMO_FACTOR) * access
                        < TIME_W'(READ_TMO)) ? TIME_W'(TMO_FACTOR) * access
                        : TIME_W'(READ_TMO);
                end else begin
                    tmo_lim <= (TIME_W'(TMO_FACTOR) * (op == OP_ERASE
                        ? erase_t : prog) < TIME_W'(WRITE_TMO))
                        ? TIME_W'(TMO_FACTOR) * (op == OP_ERASE
                        ? erase_t : prog) : TIME_W'(WRITE_TMO);
                end
            end else if (state == ST_READ || state == ST_BUSY) begin
                tmo_cnt <= tmo_cnt + 1'b1;
                tmo_flag <= tmo_cnt + 1'b1 >= tmo_lim;
            end
        end
    end

    assign link.rsp_toggle = rsp_tg;
    assign link.rsp_byte = rsp;
    assign busy_src = state == ST_BUSY;
    assign link.busy_level = busy_src;

    always_ff @(posedge clk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            operating_conditions_reg_out <= OCR_RESET;
            state_out <= '0;
            crc_check_out <= 1'b0;
            timeout_out <= 1'b0;
            op_limit_out <= '0;
        end else if (clk_en_in) begin
            operating_conditions_reg_out <= operating_conditions_reg;
            state_out <= state;
            crc_check_out <= crc_on;
            timeout_out <= tmo_flag;
            op_limit_out <= tmo_lim;
        end
    end

    chk_idle_reject: assert property (@(posedge clk_in)
        disable iff (sys_rst_in) clk_en_in && new_cmd && in_idle
        && op == OP_READ_ONE |=> rsp[RB_ILLEGAL])
        else $error("idle did not reject read");
    chk_read_reject: assert property (@(posedge clk_in)
        disable iff (sys_rst_in) clk_en_in && new_cmd && state == ST_READ
        && op != OP_STOP |=> rsp[RB_ILLEGAL])
        else $error("read did not reject command");
    chk_lock_reject: assert property (@(posedge clk_in)
        disable iff (sys_rst_in) clk_en_in && new_cmd && locked_in
        && op == OP_WRITE_ONE |=> rsp[RB_ILLEGAL] && $changed(rsp_tg))
        else $error("locked card accepted command");
    chk_every_cmd: assert property (@(posedge clk_in)
        disable iff (sys_rst_in) clk_en_in && new_cmd |=> $changed(rsp_tg))
        else $error("command got no response");
    chk_crc_reject: assert property (@(posedge clk_in)
        disable iff (sys_rst_in) clk_en_in && new_cmd && crc_bad
        |=> rsp[RB_CRC] && $stable(state))
        else $error("bad CRC accepted");
    chk_tmo_bound: assert property (@(posedge clk_in)
        disable iff (sys_rst_in) clk_en_in && tmo_flag
        |=> state == ST_READY)
        else $error("timeout did not end operation");
    chk_crc_default: assert property (@(posedge clk_in)
        disable iff (sys_rst_in) $fell(sys_rst_in) |-> !crc_on)
        else $error("CRC check on after reset");
    chk_busy_level: assert property (@(posedge clk_in)
        disable iff (sys_rst_in) clk_en_in && state == ST_BUSY
        && !op_done_in && !op_error_in && !tmo_flag
        |=> link.busy_level)
        else $error("busy dropped before the operation ended");
endmodule // card_spi_cmd
`default_nettype wire

// File: card_host_model.sv
// Host-side serial controller model that frames commands for the card
`timescale 1ns/10ps
`default_nettype none
module card_host_model
    import card_cmd_pkg::*;
(
    input wire logic miso_in,
    output logic sclk_out,
    output logic cs_n_out,
    output logic mosi_out
);
    initial begin
        sclk_out = 1'b0;
        cs_n_out = 1'b1;
        mosi_out = 1'b1;
    end

    // Clock runs only inside tasks, so it stands still between frames
    task automatic byte_x(input logic [7:0] tx, output logic [7:0] rx);
        for (int i = 7; i >= 0; i--) begin
            mosi_out = tx[i];
            #12;
            sclk_out = 1'b1;
            rx[i] = miso_in;
            #24;
            sclk_out = 1'b0;
            #12;
        end
        mosi_out = 1'b1;
    endtask

    task automatic idle_clocks(input int n);
        for (int i = 0; i < n; i++) begin
            #24;
            sclk_out = 1'b1;
            #24;
            sclk_out = 1'b0;
        end
    endtask

    function automatic logic [6:0] crc7(input logic [39:0] m);
        logic [6:0] c;
        logic fb;
        c = 7'h00;
        for (int i = 39; i >= 0; i--) begin
            fb = m[i] ^ c[6];
            c = {c[5:0], 1'b0};
            if (fb) begin
                c = c ^ CRC_POLY;
            end
        end
        return c;
    endfunction

    // Bad CRC flips the lowest check bit only
    task automatic xfer(input logic [5:0] idx, input logic [31:0] arg,
        input logic bad_crc, output logic [7:0] rsp);
        logic [47:0] f;
        logic [7:0] rx;
        f = {2'b01, idx, arg, 8'h00};
        f[7:0] = {crc7(f[47:8]) ^ {6'h00, bad_crc}, 1'b1};
        cs_n_out = 1'b0;
        for (int b = 5; b >= 0; b--) begin
            byte_x(f[b*8 +: 8], rx);
        end
        rsp = 8'hff;
        for (int n = 0; n < 8 && rsp[7] !== 1'b0; n++) begin
            byte_x(8'hff, rsp);
        end
        // Trailing clocks after the response end bit
        byte_x(8'hff, rx);
    endtask
endmodule // card_host_model
`default_nettype wire

// File: tb_top.sv
// Self-checking bench for the card command front end
`timescale 1ns/10ps
`default_nettype none
module tb_top
    import card_cmd_pkg::*;
;
    // Long enough that a read outlives the stop command that ends it
    localparam int TMO = 8000;
    logic clk_in = 1'b0;
    logic sys_rst_in = 1'b1;
    logic clk_en_in = 1'b1;
    logic sclk, cs_n, mosi, card_out, card_oe, miso_wire;
    logic locked_in = 1'b0;
    logic [31:0] access = 32'h14;
    logic [31:0] cycles = 32'h5;
    logic [2:0] wsf = 3'h2;
    logic [15:0] wbu = 16'h3;
    logic op_done_in = 1'b0;
    logic op_error_in = 1'b0;
    logic [31:0] operating_conditions_reg, op_limit;
    logic [1:0] state;
    logic crc_check, timeout;
    logic [7:0] r;
    logic seen;
    int checks = 0;
    int fail_count = 0;

    always #2 clk_in = ~clk_in;
    // Released line floats high through the host pull-up
    assign miso_wire = card_oe ? card_out : 1'b1;

    card_host_model host (.miso_in(miso_wire), .sclk_out(sclk),
        .cs_n_out(cs_n), .mosi_out(mosi));

    card_spi_cmd #(.READ_TMO(TMO), .WRITE_TMO(TMO)) DUT (
        .clk_in(clk_in), .sys_rst_in(sys_rst_in), .clk_en_in(clk_en_in),
        .sclk_in(sclk), .cs_n_in(cs_n), .mosi_in(mosi),
        .card_serial_output_out(card_out),
        .card_serial_output_oe_out(card_oe), .locked_in(locked_in),
        .async_access_time_in(access), .clocked_access_cycles_in(cycles),
        .write_speed_factor_in(wsf), .write_block_unit_in(wbu),
        .op_done_in(op_done_in), .op_error_in(op_error_in),
        .operating_conditions_reg_out(operating_conditions_reg), .state_out(state),
        .crc_check_out(crc_check), .timeout_out(timeout),
        .op_limit_out(op_limit));

    task automatic check(input string name, input logic [31:0] got,
        input logic [31:0] exp);
        checks++;
        if (got !== exp) begin
            fail_count++;
            $display("unexpected %s: expected %h seen %h", name, exp, got);
        end
    endtask

    task automatic cmd(input logic [5:0] idx, input logic [31:0] arg,
        input logic bad, input logic [7:0] exp);
        host.xfer(idx, arg, bad, r);
        check("response", {24'h0, r}, {24'h0, exp});
    endtask

    task automatic st(input logic [1:0] exp);
        for (int i = 0; i < 50 && state !== exp; i++) begin
            @(posedge clk_in);
            #1;
        end
        check("state", {30'h0, state}, {30'h0, exp});
    endtask

    task automatic wait_tmo(input int lim);
        seen = 1'b0;
        for (int i = 0; i < lim && !seen; i++) begin
            @(posedge clk_in);
            #1;
            seen = (timeout === 1'b1);
        end
    endtask

    task automatic finish_op(input logic err);
        @(posedge clk_in);
        op_done_in <= !err;
        op_error_in <= err;
        @(posedge clk_in);
        op_done_in <= 1'b0;
        op_error_in <= 1'b0;
    endtask

    task automatic results;
        $display("checks %0d fail_count %0d", checks, fail_count);
        if (fail_count == 0 && checks > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask

    initial begin
        #300000;
        fail_count++;
        results();
    end

    initial begin
        repeat (6) @(posedge clk_in);
        sys_rst_in <= 1'b0;
        @(posedge clk_in);
        check("ocr", operating_conditions_reg, 32'h00ff8000);
        check("crc_on", {31'h0, crc_check}, 32'h0);
        check("oe", {31'h0, card_oe}, 32'h0);
        st(2'd0);
        cmd(OP_RESET, 32'h0, 1'b0, 8'h01);
        cmd(OP_READ_ONE, 32'h0, 1'b0, 8'h05);
        cmd(OP_READ_OCR, 32'h0, 1'b0, 8'h01);
        cmd(OP_CRC_ONOFF, 32'h0, 1'b0, 8'h01);
        r = 8'hff;
        for (int n = 0; n < 10 && r !== 8'h00; n++) begin
            host.xfer(OP_INIT, 32'h0, 1'b0, r);
        end
        check("init", {24'h0, r}, 32'h0);
        st(2'd1);
        cmd(6'h05, 32'h0, 1'b0, 8'h04);
        cmd(OP_CRC_ONOFF, 32'h1, 1'b0, 8'h00);
        check("crc_on", {31'h0, crc_check}, 32'h1);
        cmd(OP_READ_OCR, 32'h0, 1'b1, 8'h08);
        cmd(OP_READ_OCR, 32'h0, 1'b0, 8'h00);
        cmd(OP_CRC_ONOFF, 32'h0, 1'b0, 8'h00);
        check("crc_on", {31'h0, crc_check}, 32'h0);
        @(posedge clk_in);
        locked_in <= 1'b1;
        cmd(OP_WRITE_ONE, 32'h0, 1'b0, 8'h04);
        cmd(OP_READ_OCR, 32'h0, 1'b0, 8'h00);
        @(posedge clk_in);
        locked_in <= 1'b0;
        cmd(OP_ERASE, 32'h0, 1'b0, 8'h10);
        cmd(OP_READ_ONE, 32'h0, 1'b0, 8'h00);
        st(2'd2);
        // 100 times (20 + 5), below the ceiling
        check("limit", op_limit, 32'd2500);
        cmd(OP_WRITE_ONE, 32'h0, 1'b0, 8'h04);
        cmd(OP_STOP, 32'h0, 1'b0, 8'h00);
        st(2'd1);
        cmd(OP_READ_MANY, 32'h0, 1'b0, 8'h00);
        wait_tmo(TMO + 100);
        check("read_tmo", {31'h0, seen}, 32'h1);
        cmd(OP_WRITE_ONE, 32'h0, 1'b0, 8'h00);
        st(2'd3);
        // 100 times (25 << 2) exceeds the ceiling
        check("limit", op_limit, TMO);
        host.byte_x(8'hff, r);
        check("busy_line", {24'h0, r}, 32'h0);
        finish_op(1'b0);
        st(2'd1);
        check("held_low", {31'h0, card_out}, 32'h0);
        host.byte_x(8'hff, r);
        host.byte_x(8'hff, r);
        check("released", {24'h0, r}, 32'hff);
        cmd(OP_WRITE_MANY, 32'h0, 1'b0, 8'h00);
        wait_tmo(TMO + 100);
        check("write_tmo", {31'h0, seen}, 32'h1);
        host.idle_clocks(16);
        @(posedge clk_in);
        wsf <= 3'h0;
        cmd(OP_ERASE_START, 32'h0, 1'b0, 8'h00);
        cmd(OP_ERASE_END, 32'h0, 1'b0, 8'h00);
        cmd(OP_ERASE, 32'h0, 1'b0, 8'h00);
        // 100 times (25 << 0) times 3 blocks
        check("limit", op_limit, 32'd7500);
        finish_op(1'b1);
        host.idle_clocks(16);
        st(2'd1);
        cmd(OP_RESET, 32'h0, 1'b0, 8'h01);
        st(2'd0);
        r = 8'hff;
        for (int n = 0; n < 10 && r !== 8'h00; n++) begin
            cmd(OP_APP_PREFIX, 32'h0, 1'b0, 8'h01);
            host.xfer(OP_APP_INIT, 32'h0, 1'b0, r);
        end
        check("app_init", {24'h0, r}, 32'h0);
        st(2'd1);
        results();
    end
endmodule // tb_top
`default_nettype wire
